// [rtl/sdbc_pkg.sv]
// Function
// - single close idles the selected bank, or the burst bank instead when an auto close burst ends that cycle
// - all close idles every bank at once
// - read data after CAS latency, then each edge
// - data pins float when read burst ends
// - full page bursts wrap and run until stopped
// - read mask acts two clocks later
// - read burst cut by read, write, close
// - full page ignores auto close request
// - write captures first word on command edge
// - write burst cut by write, close, read
// - read ends write; later words ignored
// - CAS latency code 010 two, 011 three
// - chip select high makes a no-operation

// ****************************************
// shared constants
// ****************************************
package sdbc_pkg;
   localparam int NB        = 4;      // banks
   localparam int BA_W      = 2;      // bank select width
   localparam int AW        = 12;     // address pins
   localparam int DW        = 16;     // data pins
   localparam int BYTE_W    = 8;      // bits per mask lane
   localparam int DM_W      = DW / BYTE_W;
   localparam int COL_W_DEF = 8;      // column address width
   localparam int AP_BIT    = 10;     // auto close / close all bit
   localparam int BL_HI     = 2;      // burst length field top
   localparam int BT_BIT    = 3;      // burst type bit
   localparam int CL_LO     = 4;      // latency field bottom
   localparam int CL_HI     = 6;      // latency field top
   localparam int WBL_BIT   = 9;      // single write bit
   localparam int PIPE_D    = 3;      // read pipe stages
   localparam int LAT_CL2   = 2;      // clocks for code 010
   localparam int LAT_CL3   = 3;      // clocks for code 011
   localparam logic [2:0] CL2_CODE = 3'h2;
   localparam logic [2:0] CL3_CODE = 3'h3;
   localparam logic [2:0] BL_FULL  = 3'h7;
   localparam logic [AW-1:0] MODE_RST = 12'h020;
   // ras, cas, we encodings
   localparam logic [2:0] ENC_ACT = 3'h3;
   localparam logic [2:0] ENC_PRE = 3'h2;
   localparam logic [2:0] ENC_RD  = 3'h5;
   localparam logic [2:0] ENC_WR  = 3'h4;
   localparam logic [2:0] ENC_MRS = 3'h0;

   // burst engine state
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RD   = 3'h2,
      ST_WR   = 3'h4
   } sdbc_state_t;

   // decoded command
   typedef enum logic [5:0] {
      CMD_NOP = 6'h01,
      CMD_ACT = 6'h02,
      CMD_PRE = 6'h04,
      CMD_RD  = 6'h08,
      CMD_WR  = 6'h10,
      CMD_MRS = 6'h20
   } sdbc_cmd_t;
endpackage

// [rtl/sdbc_if.sv]
`timescale 1ns/1ns
// ****************************************
// internal bank and read pipe signals
// ****************************************
interface sdbc_if;
   import sdbc_pkg::*;
   logic            open_v;    // row open strobe
   logic            close_v;   // close strobe
   logic            close_all; // close every bank
   logic [BA_W-1:0] bank;      // target bank
   logic [NB-1:0]   active;    // bank active flags
   logic            fetch_v;   // word enters read pipe
   logic [DW-1:0]   fetch_d;   // fetched word
   logic            cl3;       // latency three selected
   logic [DM_W-1:0] dqm;       // mask pins
   logic [DW-1:0]   rd_dq;     // read word to pins
   logic [DM_W-1:0] rd_oe;     // lane drive enables
   modport ctl  (output open_v, close_v, close_all, bank, fetch_v, fetch_d, cl3, dqm,
                 input active, rd_dq, rd_oe);
   modport bnk  (input open_v, close_v, close_all, bank, output active);
   modport pipe (input fetch_v, fetch_d, cl3, dqm, output rd_dq, rd_oe);
endinterface

// [rtl/sdbc_bank_state.sv]
`timescale 1ns/1ns
// ****************************************
// per bank idle / active tracking
// ****************************************
module sdbc_bank_state (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bank strobes
   sdbc_if.bnk      lnk
);
   import sdbc_pkg::*;
   logic [NB-1:0] act_q;  // active flags
   logic [NB-1:0] act_d;  // next flags

   // close first, then open
   always_comb begin
      act_d = act_q;
      if (lnk.close_v && lnk.close_all) begin
         act_d = '0;
      end else if (lnk.close_v) begin
         act_d[lnk.bank] = 1'b0;
      end
      if (lnk.open_v) begin
         act_d[lnk.bank] = 1'b1;
      end
   end

   // register flags
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         act_q <= '0;
      end else begin
         act_q <= act_d;
      end
   end

   assign lnk.active = act_q;

   property p_close_one;
      @(posedge clock) disable iff (!rst_n)
      lnk.close_v && !lnk.close_all |=> !lnk.active[$past(lnk.bank)];
   endproperty
   a_close_one: assert property (p_close_one) else $error("bank not idled");

   property p_close_all;
      @(posedge clock) disable iff (!rst_n)
      lnk.close_v && lnk.close_all |=> lnk.active == '0;
   endproperty
   a_close_all: assert property (p_close_all) else $error("banks left open");
endmodule

// [rtl/sdbc_rd_pipe.sv]
`timescale 1ns/1ns
// ****************************************
// read latency pipe and output mask
// ****************************************
module sdbc_rd_pipe (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // pipe signals
   sdbc_if.pipe     lnk
);
   import sdbc_pkg::*;
   logic [DW-1:0]     d_q [PIPE_D];  // word stages
   logic [DW-1:0]     d_d [PIPE_D];
   logic [PIPE_D-1:0] v_q;           // stage valid
   logic [PIPE_D-1:0] v_d;
   logic [DM_W-1:0]   m1_q;          // mask one clock old
   logic [DM_W-1:0]   m1_d;
   logic [DM_W-1:0]   m2_q;          // mask two clocks old
   logic [DM_W-1:0]   m2_d;
   int                sel;           // stage on the pins

   // shift words and mask
   always_comb begin
      d_d[0] = lnk.fetch_d;
      v_d[0] = lnk.fetch_v;
      for (int i = 1; i < PIPE_D; i++) begin
         d_d[i] = d_q[i-1];
         v_d[i] = v_q[i-1];
      end
      m1_d = lnk.dqm;
      m2_d = m1_q;
   end

   // register stages
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         d_q  <= '{default: '0};
         v_q  <= '0;
         m1_q <= '0;
         m2_q <= '0;
      end else begin
         d_q  <= d_d;
         v_q  <= v_d;
         m1_q <= m1_d;
         m2_q <= m2_d;
      end
   end

   // stage chosen by latency
   assign sel = lnk.cl3 ? (LAT_CL3 - 1) : (LAT_CL2 - 1);
   assign lnk.rd_dq = d_q[sel];
   // lane floats when empty or masked
   assign lnk.rd_oe = {DM_W{v_q[sel]}} & ~m2_q;

   property p_lat2;
      @(posedge clock) disable iff (!rst_n)
      lnk.fetch_v && !lnk.cl3 ##1 !lnk.cl3 |=> lnk.rd_dq == $past(lnk.fetch_d, 2);
   endproperty
   a_lat2: assert property (p_lat2) else $error("latency two word wrong");

   property p_lat3;
      @(posedge clock) disable iff (!rst_n)
      lnk.fetch_v && lnk.cl3 ##1 lnk.cl3 ##1 lnk.cl3 |=> lnk.rd_dq == $past(lnk.fetch_d, 3);
   endproperty
   a_lat3: assert property (p_lat3) else $error("latency three word wrong");

   property p_mask;
      @(posedge clock) disable iff (!rst_n)
      ##2 1'b1 |-> (lnk.rd_oe & $past(lnk.dqm, 2)) == '0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked lane driven");

   property p_float;
      @(posedge clock) disable iff (!rst_n)
      !lnk.fetch_v [*3] |=> lnk.rd_oe == '0;
   endproperty
   a_float: assert property (p_float) else $error("pins driven after burst");
endmodule

// [rtl/sdbc_top.sv]
`timescale 1ns/1ns
// ****************************************
// memory device command and burst core
// ****************************************
module sdbc_top #(
   parameter int COL_W = sdbc_pkg::COL_W_DEF
) (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   // command pins
   input  wire logic                      cs_n,
   input  wire logic                      ras_n,
   input  wire logic                      cas_n,
   input  wire logic                      we_n,
   input  wire logic [sdbc_pkg::BA_W-1:0] ba,
   input  wire logic [sdbc_pkg::AW-1:0]   addr,
   // data pins
   input  wire logic [sdbc_pkg::DM_W-1:0] dqm,
   input  wire logic [sdbc_pkg::DW-1:0]   dq_i,
   output wire logic [sdbc_pkg::DW-1:0]   dq_o,
   output logic      [sdbc_pkg::DW-1:0]   dq_oe
);
   import sdbc_pkg::*;

   // ****************************************
   // sizes and checks
   // ****************************************
   localparam int IW    = BA_W + COL_W;  // storage index width
   localparam int DEPTH = NB << COL_W;   // stored words

   if (COL_W < 3 || COL_W > AP_BIT) begin : g_chk
      $error("column width out of range");
   end

   // ****************************************
   // helpers
   // ****************************************
   // column of word i in a burst
   function automatic logic [COL_W-1:0] burst_col(
      input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] i,
      input logic [COL_W-1:0] m,
      input logic             ilv
   );
      logic [COL_W-1:0] sum;
      sum = s + i;
      burst_col = ilv ? (s ^ (i & m)) : ((s & ~m) | (sum & m));
   endfunction

   // last word index from length code
   function automatic logic [COL_W-1:0] len_mask(input logic [BL_HI:0] code);
      logic [COL_W-1:0] m;
      m = '0;
      unique case (code)
         3'h1:    m = COL_W'(1);
         3'h2:    m = COL_W'(3);
         3'h3:    m = COL_W'(7);
         BL_FULL: m = '1;
         default: m = '0;
      endcase
      return m;
   endfunction

   // byte lane write with mask
   function automatic logic [DW-1:0] wr_merge(
      input logic [DW-1:0]   old,
      input logic [DW-1:0]   nw,
      input logic [DM_W-1:0] m
   );
      logic [DW-1:0] r;
      r = old;
      for (int b = 0; b < DM_W; b++) begin
         if (!m[b]) begin
            r[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
         end
      end
      return r;
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   sdbc_if lnk ();                       // internal links

   sdbc_cmd_t        cmd;                // decoded command
   sdbc_state_t      st_q;               // burst state
   sdbc_state_t      st_d;
   logic [BA_W-1:0]  bank_q;             // burst bank
   logic [BA_W-1:0]  bank_d;
   logic [COL_W-1:0] start_q;            // start column
   logic [COL_W-1:0] start_d;
   logic [COL_W-1:0] idx_q;              // word index
   logic [COL_W-1:0] idx_d;
   logic [COL_W-1:0] bmask_q;            // last word index
   logic [COL_W-1:0] bmask_d;
   logic             bfull_q;            // endless burst
   logic             bfull_d;
   logic             ilv_q;              // interleaved order
   logic             ilv_d;
   logic             auto_q;             // close at end
   logic             auto_d;
   logic [AW-1:0]    mode_q;             // mode word
   logic [AW-1:0]    mode_d;
   logic [DW-1:0]    mem_q [DEPTH];      // storage
   logic [DW-1:0]    mem_d [DEPTH];

   logic             ap;                 // address bit ten
   logic [COL_W-1:0] col_in;             // column on pins
   logic             act_hit;            // target bank active
   logic             rd_ok;              // accepted read
   logic             wr_ok;              // accepted write
   logic             pre_hit;            // close hits burst
   logic             intr;               // burst cut off
   logic             full;               // full page mode
   logic [COL_W-1:0] mask;               // mode burst index
   logic [COL_W-1:0] scol;               // step column
   logic [IW-1:0]    sidx;               // step index
   logic [IW-1:0]    cidx;               // command index
   logic             cl_ok;              // latency code legal

   // ****************************************
   // command decode
   // ****************************************
   // deselect reads as no-operation
   always_comb begin
      cmd = CMD_NOP;
      if (!cs_n) begin
         unique case ({ras_n, cas_n, we_n})
            ENC_ACT: cmd = CMD_ACT;
            ENC_PRE: cmd = CMD_PRE;
            ENC_RD:  cmd = CMD_RD;
            ENC_WR:  cmd = CMD_WR;
            ENC_MRS: cmd = CMD_MRS;
            default: cmd = CMD_NOP;
         endcase
      end
   end

   // qualifiers
   assign ap      = addr[AP_BIT];
   assign col_in  = addr[COL_W-1:0];
   assign act_hit = lnk.active[ba];
   assign rd_ok   = (cmd == CMD_RD) && act_hit;
   assign wr_ok   = (cmd == CMD_WR) && act_hit;
   assign pre_hit = (cmd == CMD_PRE) && (ap || ba == bank_q);
   assign intr    = rd_ok || wr_ok || pre_hit;
   assign full    = mode_q[BL_HI:0] == BL_FULL;
   assign mask    = len_mask(mode_q[BL_HI:0]);
   assign scol    = burst_col(start_q, idx_q, bmask_q, ilv_q);
   assign sidx    = {bank_q, scol};
   assign cidx    = {ba, col_in};
   assign cl_ok   = addr[CL_HI:CL_LO] == CL2_CODE || addr[CL_HI:CL_LO] == CL3_CODE;

   // mode latency and mask pins drive pipe
   assign lnk.cl3 = mode_q[CL_HI:CL_LO] == CL3_CODE;
   assign lnk.dqm = dqm;

   // ****************************************
   // burst engine next state
   // ****************************************
   always_comb begin
      st_d          = st_q;
      bank_d        = bank_q;
      start_d       = start_q;
      idx_d         = idx_q;
      bmask_d       = bmask_q;
      bfull_d       = bfull_q;
      ilv_d         = ilv_q;
      auto_d        = auto_q;
      mode_d        = mode_q;
      mem_d         = mem_q;
      lnk.open_v    = 1'b0;
      lnk.close_v   = 1'b0;
      lnk.close_all = 1'b0;
      lnk.bank      = ba;
      lnk.fetch_v   = 1'b0;
      lnk.fetch_d   = '0;
      // running burst, unless cut off
      if (st_q != ST_IDLE && !intr) begin
         if (st_q == ST_RD) begin
            lnk.fetch_v = 1'b1;
            lnk.fetch_d = mem_q[sidx];
         end else begin
            mem_d[sidx] = wr_merge(mem_q[sidx], dq_i, dqm);
         end
         idx_d = idx_q + COL_W'(1);
         // last word ends burst
         if (!bfull_q && idx_q == bmask_q) begin
            st_d = ST_IDLE;
            if (auto_q) begin
               lnk.close_v = 1'b1;
               lnk.bank    = bank_q;
            end
         end
      end
      // new command
      unique case (cmd)
         CMD_ACT: begin
            lnk.open_v = !act_hit;
         end
         CMD_PRE: begin
            lnk.close_v   = 1'b1;
            lnk.close_all = ap;
            if (pre_hit) begin
               st_d = ST_IDLE;
            end
         end
         CMD_RD, CMD_WR: begin
            if (act_hit) begin
               bank_d  = ba;
               start_d = col_in;
               idx_d   = COL_W'(1);
               ilv_d   = mode_q[BT_BIT] && !full;
               auto_d  = ap && !full;
               bfull_d = full;
               bmask_d = mask;
               if (cmd == CMD_RD) begin
                  st_d        = ST_RD;
                  lnk.fetch_v = 1'b1;
                  lnk.fetch_d = mem_q[cidx];
               end else begin
                  st_d        = ST_WR;
                  mem_d[cidx] = wr_merge(mem_q[cidx], dq_i, dqm);
                  if (mode_q[WBL_BIT]) begin
                     bfull_d = 1'b0;
                     bmask_d = '0;
                  end
               end
               // one word burst ends now
               if (!bfull_d && bmask_d == '0) begin
                  st_d = ST_IDLE;
                  if (auto_d) begin
                     lnk.close_v = 1'b1;
                     lnk.bank    = ba;
                  end
               end
            end
         end
         CMD_MRS: begin
            if (lnk.active == '0 && cl_ok) begin
               mode_d = addr;
            end
         end
         CMD_NOP: begin
         end
      endcase
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= ST_IDLE;
         bank_q  <= '0;
         start_q <= '0;
         idx_q   <= '0;
         bmask_q <= '0;
         bfull_q <= 1'b0;
         ilv_q   <= 1'b0;
         auto_q  <= 1'b0;
         mode_q  <= MODE_RST;
      end else begin
         st_q    <= st_d;
         bank_q  <= bank_d;
         start_q <= start_d;
         idx_q   <= idx_d;
         bmask_q <= bmask_d;
         bfull_q <= bfull_d;
         ilv_q   <= ilv_d;
         auto_q  <= auto_d;
         mode_q  <= mode_d;
      end
   end

   // storage holds no reset
   always_ff @(posedge clock) begin
      mem_q <= mem_d;
   end

   // ****************************************
   // submodules and pins
   // ****************************************
   sdbc_bank_state u_bank (
      .clock (clock),
      .rst_n (rst_n),
      .lnk   (lnk.bnk)
   );

   sdbc_rd_pipe u_pipe (
      .clock (clock),
      .rst_n (rst_n),
      .lnk   (lnk.pipe)
   );

   assign dq_o = lnk.rd_dq;

   // lane enable to every bit
   always_comb begin
      for (int b = 0; b < DW; b++) begin
         dq_oe[b] = lnk.rd_oe[b / BYTE_W];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_deselect;
      @(posedge clock) disable iff (!rst_n)
      cs_n && st_q == ST_IDLE |=> st_q == ST_IDLE && $stable(mode_q);
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect acted");

   property p_idle_bank;
      @(posedge clock) disable iff (!rst_n)
      cmd == CMD_RD && !act_hit && st_q == ST_IDLE |-> !lnk.fetch_v;
   endproperty
   a_idle_bank: assert property (p_idle_bank) else $error("read of idle bank");

   property p_wr_cap;
      @(posedge clock) disable iff (!rst_n)
      wr_ok && dqm == '0 |=> mem_q[$past(cidx)] == $past(dq_i);
   endproperty
   a_wr_cap: assert property (p_wr_cap) else $error("first word not stored");

   property p_cl_set;
      @(posedge clock) disable iff (!rst_n)
      cmd == CMD_MRS && lnk.active == '0 && addr[CL_HI:CL_LO] == CL3_CODE |=> lnk.cl3;
   endproperty
   a_cl_set: assert property (p_cl_set) else $error("latency not three");

   property p_full_run;
      @(posedge clock) disable iff (!rst_n)
      st_q == ST_RD && bfull_q && !intr |=> st_q == ST_RD;
   endproperty
   a_full_run: assert property (p_full_run) else $error("full page burst ended");

   property p_no_auto;
      @(posedge clock) disable iff (!rst_n)
      (rd_ok || wr_ok) && full |=> !auto_q;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("auto close kept");

   property p_wr_cut;
      @(posedge clock) disable iff (!rst_n)
      st_q == ST_WR && rd_ok |=> st_q != ST_WR && $past(mem_q[sidx]) == mem_q[$past(sidx)];
   endproperty
   a_wr_cut: assert property (p_wr_cut) else $error("write ran past read");

   property p_pre_cut;
      @(posedge clock) disable iff (!rst_n)
      st_q == ST_RD && pre_hit |-> !lnk.fetch_v ##1 st_q == ST_IDLE;
   endproperty
   a_pre_cut: assert property (p_pre_cut) else $error("read ran past close");

   property p_wr_new;
      @(posedge clock) disable iff (!rst_n)
      st_q == ST_WR && wr_ok |=> start_q == $past(col_in) && idx_q == COL_W'(1);
   endproperty
   a_wr_new: assert property (p_wr_new) else $error("write not restarted");

   c_read:  cover property (@(posedge clock) disable iff (!rst_n) rd_ok ##1 lnk.fetch_v [*3]);
   c_write: cover property (@(posedge clock) disable iff (!rst_n) wr_ok ##1 st_q == ST_WR);
   c_r2w:   cover property (@(posedge clock) disable iff (!rst_n) st_q == ST_RD && wr_ok);
   c_auto:  cover property (@(posedge clock) disable iff (!rst_n) auto_q && lnk.close_v);
endmodule

// [testbench/sdbc_ctl_model.sv]
`timescale 1ns/1ns
// ****************************************
// controller side pin driver
// ****************************************
module sdbc_ctl_model (
   // clock
   input  wire logic                 clock,
   // command pins
   output logic                      cs_n,
   output logic                      ras_n,
   output logic                      cas_n,
   output logic                      we_n,
   output logic [sdbc_pkg::BA_W-1:0] ba,
   output logic [sdbc_pkg::AW-1:0]   addr,
   // data pins
   output logic [sdbc_pkg::DM_W-1:0] dqm,
   output logic [sdbc_pkg::DW-1:0]   dq_i
);
   import sdbc_pkg::*;
   // deselected pins from time zero
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      {ba, addr, dqm} = '0;
      dq_i = 16'h5a5a;
   end
   // one command per falling edge; callers space them
   task automatic drive(input logic s, input logic [2:0] c, input logic [BA_W-1:0] b,
                        input logic [AW-1:0] a, input logic [DM_W-1:0] m,
                        input logic wd, input logic [DW-1:0] d);
      @(negedge clock);
      {cs_n, ras_n, cas_n, we_n} = {s, c};
      ba = b;
      addr = a;
      dqm = m;  // mask chosen by caller
      // released lines flip so stale data never looks valid
      dq_i = wd ? d : ~dq_i;
   endtask
endmodule

// [testbench/sdbc_top_bench.sv]
`timescale 1ns/1ns
// ****************************************
// self checking bench with memory model
// ****************************************
module sdbc_top_bench;
   import sdbc_pkg::*;
   logic              clock;      // system clock
   logic              rst_n;      // async reset
   logic              cs_n, ras_n, cas_n, we_n;
   logic [BA_W-1:0]   ba;         // bank select
   logic [AW-1:0]     addr;       // address pins
   logic [DM_W-1:0]   dqm;        // byte masks
   logic [DW-1:0]     dq_i, dq_o, dq_oe;
   logic [31:0]       lfsr_q;     // random source
   logic [15:0]       mem [int];  // expected storage
   int                err_count, n_compared, cl;
   // device under test, eight column page
   sdbc_top #(.COL_W(3)) sdbc_top_inst (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
   sdbc_ctl_model sdbc_ctl_model_inst (.clock(clock), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i));
   // clock generator
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[15:0];
   endfunction
   task automatic cmd(input logic [2:0] c, input int b, input logic [AW-1:0] a);
      sdbc_ctl_model_inst.drive(1'b0, c, b[1:0], a, 2'h0, 1'b0, 16'h0);
   endtask
   // write burst of n words, model updated per word
   task automatic wr(input int b, input int col, input int n, input logic ap);
      logic [15:0] w;
      for (int t = 0; t < n; t++) begin
         w = rnd();
         mem[b * 8 + ((col + t) & 7)] = w;
         sdbc_ctl_model_inst.drive(1'b0, t == 0 ? ENC_WR : 3'h7, b[1:0],
            t == 0 ? 12'(col) | (12'(ap) << 10) : 12'h0, 2'h0, 1'b1, w);
      end
   endtask
   // read; mk masks low byte of one word, cut ends it by close all, idle expects no drive
   task automatic rd(input int b, input int col, input int n, input int mk,
                     input logic cut, input logic idle);
      logic [15:0] eoe;
      for (int t = 0; t <= cl + n + 1; t++) begin
         sdbc_ctl_model_inst.drive(1'b0, t == 0 ? ENC_RD : (cut && t == n) ? ENC_PRE : 3'h7,
            b[1:0], t == 0 ? 12'(col) : 12'h400, {1'b0, t == cl + mk - 2}, 1'b0, 16'h0);
         if (t >= cl && t < cl + n) begin
            eoe = idle ? 16'h0 : (t == cl + mk ? 16'hff00 : 16'hffff);
            chk(dq_oe, eoe);
            chk(dq_o & eoe, mem[b * 8 + ((col + t - cl) & 7)] & eoe);
         end
         if (t == cl + n + cut) chk(dq_oe, 16'h0);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #1000000;
      err_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      lfsr_q = 32'h9a6f;
      err_count = 0;
      n_compared = 0;
      repeat (6) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      chk(dq_oe, 16'h0);
      cl = 2;
      cmd(ENC_MRS, 0, 12'h022);
      cmd(ENC_ACT, 1, 12'h0);
      cmd(3'h7, 0, 12'h0);
      wr(1, 4, 4, 1'b0);
      rd(1, 4, 4, 99, 1'b0, 1'b0);
      wr(1, 4, 2, 1'b0);
      rd(1, 4, 4, 99, 1'b0, 1'b0);
      sdbc_ctl_model_inst.drive(1'b1, ENC_PRE, 2'h1, 12'h400, 2'h0, 1'b0, 16'h0);
      rd(1, 4, 4, 99, 1'b0, 1'b0);
      cmd(ENC_PRE, 1, 12'h0);
      rd(1, 4, 2, 99, 1'b0, 1'b1);
      // single word writes: the idle edge after must store nothing
      cmd(ENC_MRS, 0, 12'h222);
      cmd(ENC_ACT, 1, 12'h0);
      cmd(3'h7, 0, 12'h0);
      wr(1, 4, 1, 1'b0);
      cmd(3'h7, 0, 12'h0);
      rd(1, 4, 4, 99, 1'b0, 1'b0);
      cmd(ENC_PRE, 1, 12'h0);
      cl = 3;
      cmd(ENC_MRS, 0, 12'h032);
      cmd(ENC_ACT, 0, 12'h0);
      cmd(ENC_ACT, 3, 12'h0);
      wr(0, 0, 4, 1'b0);
      rd(0, 0, 4, 1, 1'b0, 1'b0);
      cmd(ENC_PRE, 0, 12'h400);
      rd(3, 0, 2, 99, 1'b0, 1'b1);
      cl = 2;
      cmd(ENC_MRS, 0, 12'h027);
      cmd(ENC_ACT, 2, 12'h0);
      cmd(3'h7, 0, 12'h0);
      wr(2, 6, 4, 1'b1);
      rd(2, 6, 4, 99, 1'b1, 1'b0);
      rd(2, 6, 2, 99, 1'b0, 1'b1);
      report_and_stop();
   end
endmodule
